//--- include/mtr_pkg.sv
// Package: constants of the transmit-status, receive-control and statistics
// block. Assumes one 250 MHz controller clock.
package mtr_pkg;

  // ------------------------------------------------------------------
  // Register offsets (bank 0, byte address of the even byte)
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_TX_STATUS = 4'h2;
  localparam logic [3:0] OFS_RX_CTRL   = 4'h4;
  localparam logic [3:0] OFS_COUNTERS  = 4'h6;

  // ------------------------------------------------------------------
  // transmit_outcome_status bit positions
  // ------------------------------------------------------------------
  localparam int ST_UNDERRUN = 15;
  localparam int ST_LINK_OK  = 14;
  localparam int ST_COUNTER_ROLLOVER_FLAG  = 12;
  localparam int ST_EXCESSIVE_DEFERRAL_FLAG  = 11;
  localparam int ST_LOST     = 10;
  localparam int ST_LATE_COLLISION_FLAG   = 9;
  localparam int ST_DEFR     = 7;
  localparam int ST_BRD      = 6;
  localparam int ST_SIGNAL_QUALITY_ERROR_FLAG     = 5;
  localparam int ST_COL16    = 4;
  localparam int ST_MULT     = 3;
  localparam int ST_MULTIPLE_COLLISION_FLAG   = 2;
  localparam int ST_SNGL     = 1;
  localparam int ST_SUC      = 0;

  // ------------------------------------------------------------------
  // receive_control bit positions and reset value
  // ------------------------------------------------------------------
  localparam int RC_SOFT_RST = 15;
  localparam int RC_CARRIER_FILTER_ENABLE = 14;
  localparam int RC_ABORT_EN = 13;
  localparam int RC_STRIP    = 9;
  localparam int RC_RECEIVE_ENABLE     = 8;
  localparam int RC_ACCEPT_ALL_MULTICAST    = 2;
  localparam int RC_PROMISCUOUS_ENABLE     = 1;
  localparam int RC_RX_ABORT = 0;
  localparam logic [15:0] RX_CTRL_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // tx_event_counters field positions (low bit of each nibble)
  // ------------------------------------------------------------------
  localparam int CN_SNGL = 0;
  localparam int CN_MUL  = 4;
  localparam int CN_DEF  = 8;
  localparam int CN_EXC  = 12;
  localparam logic [3:0] CNT_MAX = 4'hF;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int DEFER_WIN_NS    = 6400;
  // Longest time: rounds down
  localparam int DEFER_WIN_CYC   = (DEFER_WIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int EXC_DEFER_BYTES = 1518 * 2;
  localparam int LATE_COL_BYTES  = 64;
  localparam int COL_LIMIT       = 16;
  localparam int CARR_FILT_NIBS  = 3;
  localparam int RX_MAX_BYTES    = 2048;
  localparam int FCS_BYTES       = 4;

  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_DROP} mtr_rx_state_t;

endpackage

//--- design/mtr_sync.sv
// Two-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bus coherence is kept across bits.
`timescale 1ns/1ps
module mtr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // Refuse a vector with no bits at elaboration
  if (WIDTH < 1)
  begin
    $error("mtr_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

//--- design/mtr_status_rx_stats.sv
// Transmit outcome status, receive control and transmit statistics.
// Assumes the transmit engine and host port run on clk_i; PHY pins
// (carrier, collision, receive-valid, link) are asynchronous.
`timescale 1ns/1ps

module mtr_status_rx_stats (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port (bank 0 selected outside)
  input  wire logic        reg_bank0_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [1:0]  reg_be_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Transmit control bits kept elsewhere
  input  wire logic        tx_enable_set_i,
  input  wire logic        stop_on_quality_error_i,
  input  wire logic        switched_full_duplex_i,
  input  wire logic        carrier_monitor_enable_i,
  input  wire logic        full_duplex_rx_i,
  output logic             tx_enable_clear_o,
  // Transmit engine events
  input  wire logic        byte_tick_i,
  input  wire logic        tx_start_i,
  input  wire logic        tx_is_broadcast_i,
  input  wire logic        tx_is_multicast_i,
  input  wire logic        tx_preamble_end_i,
  input  wire logic        tx_deferring_i,
  input  wire logic        tx_underrun_i,
  input  wire logic        tx_done_i,
  input  wire logic        sqe_pulse_i,
  output logic             tx_jam_o,
  output logic             status_mem_we_o,
  output logic      [15:0] status_mem_data_o,
  // PHY pins
  input  wire logic        link_input_pin_n,
  input  wire logic        crs_i,
  input  wire logic        col_i,
  input  wire logic        rx_dv_i,
  // Receive path
  input  wire logic        nibble_tick_i,
  input  wire logic        rx_byte_i,
  input  wire logic        rx_da_valid_i,
  input  wire logic        rx_da_multicast_i,
  input  wire logic        rx_da_broadcast_i,
  input  wire logic        rx_da_unicast_hit_i,
  input  wire logic        rx_da_table_hit_i,
  output logic             rx_active_o,
  output logic             rx_accept_o,
  output logic             rx_abort_o,
  output logic             rx_frame_done_o,
  output logic      [11:0] rx_len_o,
  output logic             rx_store_fcs_o,
  output logic             soft_reset_o,
  output logic             link_irq_o,
  output logic             rollover_irq_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]           rdata;
    logic [15:0]           st;
    logic [15:0]           rc;
    logic [15:0]           cnt;
    logic                  tx_active;
    logic                  defer_seen;
    logic                  exc_seen;
    logic [4:0]            ncol;
    logic [6:0]            tx_bytes;
    logic [11:0]           defer_bytes;
    logic                  ifg_on;
    logic [10:0]           ifg_cyc;
    logic                  sqe_seen;
    logic                  stat_we;
    logic [15:0]           stat_data;
    logic                  txen_clr;
    logic                  jam;
    logic                  link_irq;
    logic                  rol_irq;
    logic [1:0]            cfilt;
    logic                  crs_filt;
    mtr_pkg::mtr_rx_state_t rx_state;
    logic [11:0]           rx_len;
    logic                  rx_accept;
    logic                  rx_abort_p;
    logic                  rx_done_p;
    logic [11:0]           rx_len_out;
    logic                  rx_act;
    logic                  keep_fcs;
  } mtr_state_t;

  mtr_state_t s;
  mtr_state_t next_s;
  logic [1:0] rst_sync;
  logic       rstn;
  logic [3:0] pins;
  logic       link_s;
  logic       crs_s;
  logic       col_s;
  logic       dv_s;

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rstn = rst_sync[1];

  mtr_sync #(.WIDTH(4)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn),
    .d_i    ({link_input_pin_n, crs_i, col_i, rx_dv_i}),
    .q_o    (pins)
  );
  assign {link_s, crs_s, col_s, dv_s} = pins;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic       wr_rc;
    logic       rd_cnt;
    logic       hdx;
    logic       col_ev;
    logic       fatal;
    logic       detect;
    logic [3:0] inc;
    logic [3:0] c;
    next_s = s;
    wr_rc  = reg_bank0_i && reg_wr_i && reg_addr_i == mtr_pkg::OFS_RX_CTRL;
    rd_cnt = reg_bank0_i && reg_rd_i
             && reg_addr_i == mtr_pkg::OFS_COUNTERS;
    // Full duplex blinds the transmitter to carrier and collision
    hdx    = !switched_full_duplex_i;
    col_ev = col_s && hdx && s.tx_active;
    fatal  = 1'b0;
    inc    = 4'h0;
    detect = 1'b0;
    c      = 4'h0;
    next_s.stat_we    = 1'b0;
    next_s.txen_clr   = 1'b0;
    next_s.link_irq   = 1'b0;
    next_s.rol_irq    = 1'b0;
    next_s.rx_abort_p = 1'b0;
    next_s.rx_done_p  = 1'b0;

    if (s.rc[mtr_pkg::RC_SOFT_RST])
    begin
      // Held in reset until the host writes the bit low
      next_s = '0;
      next_s.rc[mtr_pkg::RC_SOFT_RST] = 1'b1;
    end
    else
    begin
      // Link level and change event
      next_s.st[mtr_pkg::ST_LINK_OK] = !link_s;
      if (s.st[mtr_pkg::ST_LINK_OK] == link_s)
        next_s.link_irq = 1'b1;

      // Re-enabling transmit clears sticky errors; events below win
      if (tx_enable_set_i)
      begin
        next_s.st[mtr_pkg::ST_UNDERRUN] = 1'b0;
        next_s.st[mtr_pkg::ST_LOST]     = 1'b0;
        next_s.st[mtr_pkg::ST_LATE_COLLISION_FLAG]   = 1'b0;
        next_s.st[mtr_pkg::ST_SIGNAL_QUALITY_ERROR_FLAG]     = 1'b0;
        next_s.st[mtr_pkg::ST_COL16]    = 1'b0;
        next_s.st[mtr_pkg::ST_SUC]      = 1'b0;
      end
      if (!stop_on_quality_error_i)
        next_s.st[mtr_pkg::ST_SIGNAL_QUALITY_ERROR_FLAG] = 1'b0;

      if (tx_start_i)
      begin
        if (s.st[mtr_pkg::ST_SUC])
        begin
          next_s.st[mtr_pkg::ST_SNGL]   = 1'b0;
          next_s.st[mtr_pkg::ST_MULTIPLE_COLLISION_FLAG] = 1'b0;
        end
        next_s.st[mtr_pkg::ST_SUC]  = 1'b0;
        next_s.st[mtr_pkg::ST_BRD]  = tx_is_broadcast_i;
        next_s.st[mtr_pkg::ST_MULT] = tx_is_multicast_i;
        next_s.tx_active = 1'b1;
        next_s.ncol      = 5'h00;
        next_s.tx_bytes  = 7'h00;
        next_s.jam       = 1'b0;
      end
      else if (s.tx_active && byte_tick_i
               && s.tx_bytes != 7'(mtr_pkg::LATE_COL_BYTES))
        next_s.tx_bytes = s.tx_bytes + 7'h01;

      // Deferral length, counted in byte times
      if (tx_deferring_i && hdx && byte_tick_i)
      begin
        if (s.defer_bytes != 12'(mtr_pkg::EXC_DEFER_BYTES))
          next_s.defer_bytes = s.defer_bytes + 12'h001;
        else
        begin
          next_s.st[mtr_pkg::ST_EXCESSIVE_DEFERRAL_FLAG] = 1'b1;
          next_s.exc_seen = 1'b1;
        end
      end

      // Early part of the interframe gap
      if (s.ifg_on)
      begin
        next_s.ifg_cyc = s.ifg_cyc + 11'h001;
        if (crs_s && hdx)
        begin
          next_s.st[mtr_pkg::ST_DEFR] = 1'b1;
          next_s.defer_seen = 1'b1;
        end
        if (sqe_pulse_i)
          next_s.sqe_seen = 1'b1;
        if (s.ifg_cyc == 11'(mtr_pkg::DEFER_WIN_CYC - 1))
        begin
          next_s.ifg_on = 1'b0;
          // Checked when the gap window closes; only then is absence known
          if (stop_on_quality_error_i && hdx && !s.sqe_seen && !sqe_pulse_i)
          begin
            next_s.st[mtr_pkg::ST_SIGNAL_QUALITY_ERROR_FLAG] = 1'b1;
            next_s.st[mtr_pkg::ST_SUC]  = 1'b0;
            next_s.txen_clr = 1'b1;
          end
        end
      end

      if (tx_underrun_i)
      begin
        next_s.st[mtr_pkg::ST_UNDERRUN] = 1'b1;
        next_s.txen_clr = 1'b1;
      end
      if (tx_preamble_end_i && carrier_monitor_enable_i && hdx && !crs_s)
      begin
        next_s.st[mtr_pkg::ST_LOST] = 1'b1;
        next_s.txen_clr = 1'b1;
      end

      if (col_ev && s.ncol != 5'(mtr_pkg::COL_LIMIT))
      begin
        next_s.ncol = s.ncol + 5'h01;
        next_s.st[mtr_pkg::ST_SNGL] = 1'b1;
        if (s.ncol != 5'h00)
          next_s.st[mtr_pkg::ST_MULTIPLE_COLLISION_FLAG] = 1'b1;
        if (s.tx_bytes == 7'(mtr_pkg::LATE_COL_BYTES))
        begin
          next_s.st[mtr_pkg::ST_LATE_COLLISION_FLAG] = 1'b1;
          next_s.jam      = 1'b1;
          next_s.txen_clr = 1'b1;
        end
        if (s.ncol == 5'(mtr_pkg::COL_LIMIT - 1))
        begin
          next_s.st[mtr_pkg::ST_COL16] = 1'b1;
          next_s.txen_clr = 1'b1;
        end
      end

      // Statistics: read clears first, then this packet's increment
      if (rd_cnt)
      begin
        next_s.cnt = 16'h0000;
        next_s.st[mtr_pkg::ST_COUNTER_ROLLOVER_FLAG] = 1'b0;
      end

      if (tx_done_i)
      begin
        fatal = next_s.st[mtr_pkg::ST_COL16] | next_s.st[mtr_pkg::ST_SIGNAL_QUALITY_ERROR_FLAG]
              | next_s.st[mtr_pkg::ST_UNDERRUN]
              | next_s.st[mtr_pkg::ST_LOST]
              | next_s.st[mtr_pkg::ST_LATE_COLLISION_FLAG];
        next_s.st[mtr_pkg::ST_SUC] = !fatal;
        inc[0] = !fatal && next_s.ncol == 5'h01;
        inc[1] = next_s.ncol >= 5'h02;
        inc[2] = next_s.defer_seen | tx_deferring_i;
        inc[3] = next_s.exc_seen;
        // Snapshot taken before end-of-packet clears
        next_s.stat_we   = 1'b1;
        next_s.stat_data = next_s.st;
        next_s.st[mtr_pkg::ST_EXCESSIVE_DEFERRAL_FLAG] = 1'b0;
        next_s.st[mtr_pkg::ST_DEFR]    = 1'b0;
        next_s.defer_seen  = 1'b0;
        next_s.exc_seen    = 1'b0;
        next_s.defer_bytes = 12'h000;
        next_s.tx_active   = 1'b0;
        next_s.jam         = 1'b0;
        next_s.ifg_on      = 1'b1;
        next_s.ifg_cyc     = 11'h000;
        next_s.sqe_seen    = 1'b0;
      end

      for (int k = 0; k < 4; k++)
      begin
        c = next_s.cnt[k*4 +: 4];
        if (inc[k] && c != mtr_pkg::CNT_MAX)
        begin
          next_s.cnt[k*4 +: 4] = c + 4'h1;
          if (c == mtr_pkg::CNT_MAX - 4'h1)
          begin
            next_s.st[mtr_pkg::ST_COUNTER_ROLLOVER_FLAG] = 1'b1;
            next_s.rol_irq = 1'b1;
          end
        end
      end

      // Receive carrier filter
      if (!crs_s)
      begin
        next_s.cfilt    = 2'h0;
        next_s.crs_filt = 1'b0;
      end
      else if (!s.rc[mtr_pkg::RC_CARRIER_FILTER_ENABLE])
        next_s.crs_filt = 1'b1;
      else if (nibble_tick_i)
      begin
        if (s.cfilt == 2'(mtr_pkg::CARR_FILT_NIBS - 1))
          next_s.crs_filt = 1'b1;
        else
          next_s.cfilt = s.cfilt + 2'h1;
      end
      detect = s.crs_filt | dv_s;

      case (s.rx_state)
        mtr_pkg::RX_IDLE:
        begin
          next_s.rx_accept = 1'b0;
          if (detect && s.rc[mtr_pkg::RC_RECEIVE_ENABLE])
          begin
            next_s.rx_state = mtr_pkg::RX_FRAME;
            next_s.rx_len   = 12'h000;
          end
        end
        mtr_pkg::RX_FRAME:
        begin
          // Enable is not looked at here so the frame completes
          if (!detect)
          begin
            next_s.rx_state   = mtr_pkg::RX_IDLE;
            next_s.rx_done_p  = 1'b1;
            next_s.rx_len_out = s.rc[mtr_pkg::RC_STRIP]
                              ? s.rx_len - 12'(mtr_pkg::FCS_BYTES)
                              : s.rx_len;
          end
          else if (col_s && s.rc[mtr_pkg::RC_ABORT_EN] && hdx)
          begin
            next_s.rx_state   = mtr_pkg::RX_DROP;
            next_s.rx_abort_p = 1'b1;
            next_s.rx_accept  = 1'b0;
          end
          else if (rx_byte_i)
          begin
            if (s.rx_len == 12'(mtr_pkg::RX_MAX_BYTES))
            begin
              next_s.rx_state   = mtr_pkg::RX_DROP;
              next_s.rx_abort_p = 1'b1;
              next_s.rx_accept  = 1'b0;
              next_s.rc[mtr_pkg::RC_RX_ABORT] = 1'b1;
            end
            else
              next_s.rx_len = s.rx_len + 12'h001;
          end
          if (rx_da_valid_i && detect)
          begin
            if (s.rc[mtr_pkg::RC_PROMISCUOUS_ENABLE])
              next_s.rx_accept = full_duplex_rx_i
                               || !s.tx_active;
            else
              next_s.rx_accept = rx_da_unicast_hit_i
                || rx_da_broadcast_i
                || (rx_da_multicast_i && (s.rc[mtr_pkg::RC_ACCEPT_ALL_MULTICAST]
                    || rx_da_table_hit_i));
          end
        end
        mtr_pkg::RX_DROP:
        begin
          if (!detect)
            next_s.rx_state = mtr_pkg::RX_IDLE;
        end
        default:
          next_s.rx_state = mtr_pkg::RX_IDLE;
      endcase
    end

    // Host writes to receive_control; reserved bits stay zero
    if (wr_rc)
    begin
      if (reg_be_i[1])
      begin
        next_s.rc[mtr_pkg::RC_SOFT_RST] = reg_wdata_i[mtr_pkg::RC_SOFT_RST];
        next_s.rc[mtr_pkg::RC_CARRIER_FILTER_ENABLE] = reg_wdata_i[mtr_pkg::RC_CARRIER_FILTER_ENABLE];
        next_s.rc[mtr_pkg::RC_ABORT_EN] = reg_wdata_i[mtr_pkg::RC_ABORT_EN];
        next_s.rc[mtr_pkg::RC_STRIP]    = reg_wdata_i[mtr_pkg::RC_STRIP];
        next_s.rc[mtr_pkg::RC_RECEIVE_ENABLE]     = reg_wdata_i[mtr_pkg::RC_RECEIVE_ENABLE];
      end
      if (reg_be_i[0])
      begin
        next_s.rc[mtr_pkg::RC_ACCEPT_ALL_MULTICAST] = reg_wdata_i[mtr_pkg::RC_ACCEPT_ALL_MULTICAST];
        next_s.rc[mtr_pkg::RC_PROMISCUOUS_ENABLE]  = reg_wdata_i[mtr_pkg::RC_PROMISCUOUS_ENABLE];
        // A new abort in the same cycle outranks the host's clear
        if (!next_s.rx_abort_p || s.rc[mtr_pkg::RC_SOFT_RST])
          next_s.rc[mtr_pkg::RC_RX_ABORT] =
            reg_wdata_i[mtr_pkg::RC_RX_ABORT];
      end
    end

    // Read data, one cycle after the strobe
    next_s.rdata = 16'h0000;
    if (reg_bank0_i && reg_rd_i)
    begin
      case (reg_addr_i)
        mtr_pkg::OFS_TX_STATUS: next_s.rdata = s.st;
        mtr_pkg::OFS_RX_CTRL:   next_s.rdata = s.rc;
        mtr_pkg::OFS_COUNTERS:  next_s.rdata = s.cnt;
        default:                next_s.rdata = 16'h0000;
      endcase
    end
    // Registered here so these pins come straight from flip-flops
    next_s.rx_act   = next_s.rx_state == mtr_pkg::RX_FRAME;
    next_s.keep_fcs = !next_s.rc[mtr_pkg::RC_STRIP];
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign reg_rdata_o       = s.rdata;
  assign tx_enable_clear_o = s.txen_clr;
  assign tx_jam_o          = s.jam;
  assign status_mem_we_o   = s.stat_we;
  assign status_mem_data_o = s.stat_data;
  assign rx_active_o       = s.rx_act;
  assign rx_accept_o       = s.rx_accept;
  assign rx_abort_o        = s.rx_abort_p;
  assign rx_frame_done_o   = s.rx_done_p;
  assign rx_len_o          = s.rx_len_out;
  assign rx_store_fcs_o    = s.keep_fcs;
  assign soft_reset_o      = s.rc[mtr_pkg::RC_SOFT_RST];
  assign link_irq_o        = s.link_irq;
  assign rollover_irq_o    = s.rol_irq;

endmodule

//--- testbench/mtr_status_rx_stats_monitor.sv
// Checker for the status, receive-control and statistics block.
// Sees only the top module's ports; bound from the bench top file.
`timescale 1ns/1ps
module mtr_status_rx_stats_monitor (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        tx_start_i,
  input wire logic        tx_is_broadcast_i,
  input wire logic        tx_is_multicast_i,
  input wire logic        tx_underrun_i,
  input wire logic        tx_done_i,
  input wire logic        link_input_pin_n,
  input wire logic        tx_enable_clear_o,
  input wire logic        status_mem_we_o,
  input wire logic [15:0] status_mem_data_o,
  input wire logic        rx_frame_done_o,
  input wire logic        link_irq_o
);
  logic brd;
  logic mul;
  logic ur;
  // Class is latched at start, as the engine only qualifies it there
  always_ff @(posedge clk_i) if (tx_start_i) brd <= tx_is_broadcast_i;
  always_ff @(posedge clk_i) if (tx_start_i) mul <= tx_is_multicast_i;
  always_ff @(posedge clk_i) ur <= tx_underrun_i | (ur & !tx_start_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_status_write:
    assert property (tx_done_i |=> status_mem_we_o) else $error("no word");
  a_word_cause:
    assert property (status_mem_we_o |-> $past(tx_done_i)) else $error("we");
  a_underrun_clr:
    assert property (tx_underrun_i |=> tx_enable_clear_o) else $error("ur");
  a_word_fatal:
    assert property (status_mem_we_o && ur |->
      {status_mem_data_o[15], status_mem_data_o[0]} == 2'h2) else $error("f");
  a_word_class:
    assert property (status_mem_we_o |-> status_mem_data_o[6] == brd &&
      status_mem_data_o[3] == mul) else $error("class");
  a_word_link:
    assert property (status_mem_we_o |->
      status_mem_data_o[14] != $past(link_input_pin_n, 3))
      else $error("link");
  a_link_irq:
    assert property ($changed(link_input_pin_n) |-> ##[1:5] link_irq_o)
      else $error("irq");
  a_done_pulse:
    assert property (rx_frame_done_o |=> !rx_frame_done_o) else $error("d");
endmodule

//--- testbench/mtr_phy_model.sv
// PHY stand-in: carrier and receive-valid for one frame per go pulse.
// Both fall between frames; it never makes a collision.
`timescale 1ns/1ps
module mtr_phy_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  output logic      crs_o,
  output logic      dv_o,
  output logic      col_o
);
  int n = 0;
  initial {crs_o, dv_o, col_o} = 3'h0;
  always @(posedge clk_i)
  begin
    n = go_i ? 40 : (n > 0 ? n - 1 : 0);
    #1;
    crs_o = n > 0;
    dv_o = n > 2;
  end
endmodule

//--- testbench/mtr_status_rx_stats_tb.sv
// Bench for the status, receive-control and statistics block.
// Inputs change 1 ns after the rising edge; carrier, collision and receive-valid from the model.
`timescale 1ns/1ps
module mtr_status_rx_stats_tb;
  logic clk_i = 0, rstn_i = 0, reg_bank0_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0] reg_addr_i = 0;
  logic [1:0] reg_be_i = 3;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o, status_mem_data_o;
  logic tx_enable_set_i = 0, tx_start_i = 0, tx_underrun_i = 0;
  logic tx_done_i = 0, tx_deferring_i = 0, link_input_pin_n = 0;
  logic stop_on_quality_error_i = 0, switched_full_duplex_i = 0;
  logic carrier_monitor_enable_i = 0, full_duplex_rx_i = 0, phy_go = 0;
  logic byte_tick_i = 0, nibble_tick_i = 0, rx_byte_i = 0, sqe_pulse_i = 0;
  logic rx_da_valid_i = 0, rx_da_multicast_i = 0, rx_da_broadcast_i = 0;
  logic rx_da_unicast_hit_i = 0, rx_da_table_hit_i = 0, tx_preamble_end_i = 0;
  logic tx_is_broadcast_i = 0, tx_is_multicast_i = 0, crs_i, col_i, rx_dv_i;
  logic [11:0] rx_len_o;
  logic tx_enable_clear_o, tx_jam_o, status_mem_we_o, rx_active_o;
  logic rx_accept_o, rx_abort_o, rx_frame_done_o, rx_store_fcs_o;
  logic soft_reset_o, link_irq_o, rollover_irq_o, rd_seen = 0, act;
  logic [31:0] q[$], e;
  int seed = 38307, n_errors = 0, samples_checked = 0, cyc = 0, k;
  int n_rol = 0;
  mtr_status_rx_stats DUT (.*);
  mtr_phy_model PHY (.clk_i, .go_i(phy_go), .crs_o(crs_i), .dv_o(rx_dv_i),
    .col_o(col_i));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) #1 {byte_tick_i, nibble_tick_i, rx_byte_i,
    sqe_pulse_i, rx_da_valid_i, rx_da_multicast_i, rx_da_broadcast_i,
    rx_da_unicast_hit_i, rx_da_table_hit_i, tx_preamble_end_i,
    tx_is_broadcast_i, tx_is_multicast_i} = 12'($random(seed));
  always @(posedge clk_i) rd_seen <= reg_rd_i;
  always @(negedge clk_i) n_rol += rollover_irq_o;
  // Whole run is about 30000 cycles
  always @(posedge clk_i) if (++cyc == 60000)
  begin
    n_errors++;
    end_of_test();
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge clk_i) if (rd_seen || status_mem_we_o)
  begin
    // A result with no note behind it is a mismatch, not a skip
    if (q.size() == 0) chk("unnoted", 16'h0001, 16'h0000);
    else
    begin
      e = q.pop_front();
      if (rd_seen) chk("rdata", reg_rdata_o & e[31:16], e[15:0]);
      else chk("word", status_mem_data_o & e[31:16], e[15:0]);
    end
  end
  // Reads note the masked value expected; d is write data or that value
  task rw(input logic w, b, input logic [3:0] a, input logic [15:0] d, m);
    @(posedge clk_i) #1;
    {reg_addr_i, reg_wdata_i} = {a, d};
    {reg_bank0_i, reg_wr_i, reg_rd_i} = {b, w, !w};
    if (!w) q.push_back({m, d & m});
    @(posedge clk_i) #1;
    {reg_wr_i, reg_rd_i, reg_bank0_i} = 3'h1;
  endtask
  task pkt(input logic ur, df);
    @(posedge clk_i) #1 {tx_start_i, tx_deferring_i} = {1'b1, df};
    @(posedge clk_i) #1 {tx_start_i, tx_underrun_i} = {1'b0, ur};
    @(posedge clk_i) #1 {tx_underrun_i, tx_done_i} = 2'h1;
    q.push_back({16'h8001, ur, 14'h0, !ur});
    @(posedge clk_i) #1 {tx_done_i, tx_deferring_i} = 2'h0;
    repeat (1610) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    #1 rstn_i = 1;
    repeat (3) @(posedge clk_i);
    rw(0, 1, 4'h4, 16'h0000, 16'hFFFF);
    rw(0, 1, 4'h8, 16'h0000, 16'hFFFF);
    rw(0, 0, 4'h6, 16'h0000, 16'hFFFF);
    for (k = 0; k < 2; k++)
    begin
      rw(1, 1, 4'h4, k ? 16'h0206 : 16'h0306, 16'hFFFF);
      rw(0, 1, 4'h4, k ? 16'h0206 : 16'h0306, 16'hFFFF);
      chk("keep_fcs", {15'h0, rx_store_fcs_o}, 16'h0000);
      @(posedge clk_i) #1 phy_go = 1;
      @(posedge clk_i) #1 phy_go = 0;
      act = 0;
      repeat (60) @(negedge clk_i) act |= rx_active_o;
      chk("rx_active", {15'h0, act}, 16'(k == 0));
    end
    rw(0, 1, 4'h2, 16'h4000, 16'h4000);
    @(posedge clk_i) #1 link_input_pin_n = 1;
    // Pin passes two synchroniser stages before the bit moves
    repeat (3) @(posedge clk_i);
    rw(0, 1, 4'h2, 16'h0000, 16'h4000);
    pkt(1, 0);
    rw(0, 1, 4'h2, 16'h8000, 16'h8001);
    @(posedge clk_i) #1 tx_enable_set_i = 1;
    @(posedge clk_i) #1 tx_enable_set_i = 0;
    rw(0, 1, 4'h2, 16'h0000, 16'h8001);
    repeat (16) pkt(0, 1);
    rw(0, 1, 4'h2, 16'h1000, 16'h1000);
    chk("rol_irq", 16'(n_rol), 16'h0001);
    rw(0, 1, 4'h6, 16'h0F00, 16'hFFFF);
    rw(0, 1, 4'h6, 16'h0000, 16'hFFFF);
    rw(0, 1, 4'h2, 16'h0000, 16'h1000);
    rw(1, 1, 4'h4, 16'h8000, 16'hFFFF);
    rw(0, 1, 4'h4, 16'h8000, 16'hFFFF);
    chk("soft_rst", {15'h0, soft_reset_o}, 16'h0001);
    rw(0, 1, 4'h2, 16'h0000, 16'h0001);
    rw(1, 1, 4'h4, 16'h0000, 16'hFFFF);
    chk("soft_rst", {15'h0, soft_reset_o}, 16'h0000);
    // Let the last read note be taken before the verdict
    repeat (2) @(posedge clk_i);
    chk("notes_left", 16'(q.size()), 16'h0000);
    end_of_test();
  end
endmodule
bind mtr_status_rx_stats mtr_status_rx_stats_monitor u_mon (.*);
